// ### bus_handover_map.vh
// Constants for the host bus handover block
`ifndef BUS_HANDOVER_MAP_VH
`define BUS_HANDOVER_MAP_VH
`define NUM_PROCS       6
`define ID_WIDTH        3
`define ID_SINGLE       3'h0
`define ACK_SEL_RESET   1'b0
`define DMA_CH_FIRST    7
`define DMA_CH_SECOND   8
`define DMA_REQ_WIDTH   2
`endif

// ### pin_sync.v
// Two-flop synchroniser for a vector of pin inputs
`timescale 1ns/1ps
module pin_sync #(
  parameter WIDTH = 1
) (
  input  wire             clk,
  input  wire             arst_n,
  input  wire [WIDTH-1:0] async_in,
  output reg  [WIDTH-1:0] sync_out
);
  reg [WIDTH-1:0] meta_q;
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      meta_q   <= {WIDTH{1'b1}};
      sync_out <= {WIDTH{1'b1}};
    end else begin
      meta_q   <= async_in;
      sync_out <= meta_q;
    end
  end
endmodule

// ### host_bus_handover.v
// Host bus handover, host access acknowledge and bus request pin control
//
// Overview of operation
// - Bus master releases bus, then grants host
// - Release tri-states address, data, selects, strobes
// - Host request beats every peer request
// - Grant held low until request withdrawn
// - Only bus master drives grant; others observe
// - Acknowledge low inserts host wait states
// - Acknowledge open-drain after reset; bit selects active
// - Acknowledge driven only with select and request
// - Drive own request line only, monitor others
`timescale 1ns/1ps
`include "bus_handover_map.vh"
module host_bus_handover #(
  parameter NPROC = `NUM_PROCS,
  parameter IDW   = `ID_WIDTH
) (
  // Clock and reset
  input  wire             CLK,
  input  wire             ARST_N,
  // Host request and grant, active low
  input  wire             HOST_BUS_REQUEST_N,
  input  wire             HOST_BUS_GRANT_N_IN,
  output reg              HOST_BUS_GRANT_N_OUT,
  output reg              HOST_BUS_GRANT_N_OE,
  // Host access, active low
  input  wire             CHIP_SELECT_N,
  input  wire             ACCESS_BUSY,
  output reg              HOST_ACCESS_ACK_OUT,
  output reg              HOST_ACCESS_ACK_OE,
  // Configuration from the system control register
  input  wire             ACK_ACTIVE_DRIVE_SEL,
  // Processor ID and bus request lines, active low
  input  wire [IDW-1:0]   PROCESSOR_ID_INPUTS,
  input  wire [NPROC-1:0] MP_BUS_REQUEST_N_IN,
  output reg  [NPROC-1:0] MP_BUS_REQUEST_N_OUT,
  output reg  [NPROC-1:0] MP_BUS_REQUEST_N_OE,
  // Core side: own need for the bus and mastership
  input  wire             CORE_BUS_NEED,
  input  wire             IS_BUS_MASTER,
  input  wire             BUS_CYCLE_IDLE,
  output reg              EXT_BUS_OE,
  output reg              HOST_OWNS_BUS,
  output reg              PEER_REQUEST_SEEN,
  output reg              OBSERVED_HOST_GRANT,
  // External DMA requests, active low, bit 0 channel 7, bit 1 channel 8
  input  wire [`DMA_REQ_WIDTH-1:0] EXT_DMA_REQUEST_N,
  output reg  [`DMA_REQ_WIDTH-1:0] DMA_CH_REQUEST
);

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  // All pin inputs pass two flops before any logic
  localparam SW = NPROC + `DMA_REQ_WIDTH + 3;
  wire [SW-1:0] pins_async = {HOST_BUS_REQUEST_N, CHIP_SELECT_N, HOST_BUS_GRANT_N_IN,
                              EXT_DMA_REQUEST_N, MP_BUS_REQUEST_N_IN};
  wire [SW-1:0] pins_sync;

  pin_sync #(.WIDTH(SW)) u_sync (
    .clk       (CLK),
    .arst_n    (ARST_N),
    .async_in  (pins_async),
    .sync_out  (pins_sync)
  );

  wire                      hbr_s  = ~pins_sync[SW-1];
  wire                      cs_s   = ~pins_sync[SW-2];
  wire                      hbg_s  = ~pins_sync[SW-3];
  wire [`DMA_REQ_WIDTH-1:0] dmar_s = ~pins_sync[NPROC +: `DMA_REQ_WIDTH];
  wire [NPROC-1:0]          br_s   = ~pins_sync[NPROC-1:0];

  // ****************************************************************
  // ID decode and strap capture
  // ****************************************************************
  function [NPROC-1:0] id_onehot;
    input [IDW-1:0] id;
    integer k;
    begin
      id_onehot = {NPROC{1'b0}};
      for (k = 0; k < NPROC; k = k + 1) begin
        if (id == k + 1)
          id_onehot[k] = 1'b1;
      end
    end
  endfunction

  // Straps resync here; the reset value selects no line
  wire [IDW-1:0] id_s;

  pin_sync #(.WIDTH(IDW)) u_id_sync (
    .clk      (CLK),
    .arst_n   (ARST_N),
    .async_in (PROCESSOR_ID_INPUTS),
    .sync_out (id_s)
  );

  reg [NPROC-1:0] own_line_q;
  always @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N)
      own_line_q <= {NPROC{1'b0}};
    else
      own_line_q <= id_onehot(id_s);
  end

  // ****************************************************************
  // Handover state machine
  // ****************************************************************
  // Slave: another processor masters the bus
  localparam [3:0] S_OWN     = 4'h1;
  localparam [3:0] S_RELEASE = 4'h2;
  localparam [3:0] S_GRANT   = 4'h4;
  localparam [3:0] S_SLAVE   = 4'h8;

  reg [3:0] state_q;
  reg [3:0] state_d;

  // Grant only after the current bus cycle has ended
  always @* begin
    state_d = state_q;
    case (state_q)
      S_OWN: begin
        if (!IS_BUS_MASTER)
          state_d = S_SLAVE;
        else if (hbr_s)
          state_d = S_RELEASE;
      end
      S_RELEASE: begin
        if (!hbr_s)
          state_d = S_OWN;
        else if (BUS_CYCLE_IDLE)
          state_d = S_GRANT;
      end
      S_GRANT: begin
        // Grant held until the synchronised request drops
        if (!hbr_s)
          state_d = S_OWN;
      end
      S_SLAVE: begin
        if (IS_BUS_MASTER)
          state_d = S_OWN;
      end
      default: state_d = S_SLAVE;
    endcase
  end

  always @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N)
      state_q <= S_SLAVE;
    else
      state_q <= state_d;
  end

  // ****************************************************************
  // Grant line and external bus drivers
  // ****************************************************************
  // Grant pad driven only while this device is master
  wire granting  = (state_d == S_GRANT);
  wire drive_bus = (state_d == S_OWN) & ~hbr_s & CORE_BUS_NEED;

  always @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      HOST_BUS_GRANT_N_OUT <= 1'b1;
      HOST_BUS_GRANT_N_OE  <= 1'b0;
      EXT_BUS_OE           <= 1'b0;
      HOST_OWNS_BUS        <= 1'b0;
      OBSERVED_HOST_GRANT  <= 1'b0;
    end else begin
      HOST_BUS_GRANT_N_OUT <= ~granting;
      HOST_BUS_GRANT_N_OE  <= IS_BUS_MASTER & (state_d != S_SLAVE);
      EXT_BUS_OE           <= drive_bus;
      HOST_OWNS_BUS        <= granting;
      OBSERVED_HOST_GRANT  <= hbg_s;
    end
  end

  // ****************************************************************
  // Host access acknowledge
  // ****************************************************************
  // Open-drain mode enables the pad only while pulling low
  wire ack_en    = cs_s & hbr_s;
  wire ack_level = ~ACCESS_BUSY;

  always @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      HOST_ACCESS_ACK_OUT <= 1'b0;
      HOST_ACCESS_ACK_OE  <= 1'b0;
    end else begin
      HOST_ACCESS_ACK_OUT <= ack_level;
      if (ACK_ACTIVE_DRIVE_SEL)
        HOST_ACCESS_ACK_OE <= ack_en;
      else
        HOST_ACCESS_ACK_OE <= ack_en & ~ack_level;
    end
  end

  // ****************************************************************
  // Bus request lines, peer status and DMA requests
  // ****************************************************************
  // A host request also withdraws the own peer request
  wire peer_req = |(br_s & ~own_line_q);
  wire own_req  = CORE_BUS_NEED & ~hbr_s;

  always @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      MP_BUS_REQUEST_N_OUT <= {NPROC{1'b1}};
      MP_BUS_REQUEST_N_OE  <= {NPROC{1'b0}};
      PEER_REQUEST_SEEN    <= 1'b0;
      DMA_CH_REQUEST       <= {`DMA_REQ_WIDTH{1'b0}};
    end else begin
      MP_BUS_REQUEST_N_OUT <= ~(own_line_q & {NPROC{own_req}});
      MP_BUS_REQUEST_N_OE  <= own_line_q;
      PEER_REQUEST_SEEN    <= peer_req & ~hbr_s;
      DMA_CH_REQUEST       <= dmar_s;
    end
  end

endmodule

// ### hbh_checker.sv
// Assertion checker for the host bus handover block
`timescale 1ns/1ps
module hbh_checker #(
  parameter NPROC = 6,
  parameter IDW   = 3
) (
  // Clock and reset
  input wire             CLK,
  input wire             ARST_N,
  // Host request and grant
  input wire             HOST_BUS_REQUEST_N,
  input wire             HOST_BUS_GRANT_N_OUT,
  input wire             HOST_BUS_GRANT_N_OE,
  // Host access acknowledge
  input wire             CHIP_SELECT_N,
  input wire             HOST_ACCESS_ACK_OUT,
  input wire             HOST_ACCESS_ACK_OE,
  input wire             ACK_ACTIVE_DRIVE_SEL,
  // Core side and bus drivers
  input wire             IS_BUS_MASTER,
  input wire             BUS_CYCLE_IDLE,
  input wire             EXT_BUS_OE,
  input wire             HOST_OWNS_BUS,
  input wire             PEER_REQUEST_SEEN,
  // Request lines
  input wire [IDW-1:0]   PROCESSOR_ID_INPUTS,
  input wire [NPROC-1:0] MP_BUS_REQUEST_N_OE
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!ARST_N);
  sequence s_held; !HOST_BUS_REQUEST_N [*3]; endsequence
  property p_grant;
    (!HOST_BUS_REQUEST_N && IS_BUS_MASTER && BUS_CYCLE_IDLE) [*6] |-> !HOST_BUS_GRANT_N_OUT;
  endproperty
  property p_hiz; !HOST_BUS_GRANT_N_OUT |-> !EXT_BUS_OE; endproperty
  property p_prio; s_held ##1 s_held |-> !PEER_REQUEST_SEEN; endproperty
  property p_hold;
    s_held ##0 (HOST_OWNS_BUS && !HOST_BUS_GRANT_N_OUT) |=> HOST_OWNS_BUS && !HOST_BUS_GRANT_N_OUT;
  endproperty
  property p_goe; !IS_BUS_MASTER [*3] |-> !HOST_BUS_GRANT_N_OE; endproperty
  property p_od;
    !$past(ACK_ACTIVE_DRIVE_SEL) && HOST_ACCESS_ACK_OE |-> !HOST_ACCESS_ACK_OUT;
  endproperty
  property p_ackoff; (HOST_BUS_REQUEST_N || CHIP_SELECT_N) [*4] |-> !HOST_ACCESS_ACK_OE; endproperty
  property p_own;
    MP_BUS_REQUEST_N_OE != '0 |->
      $onehot(MP_BUS_REQUEST_N_OE) && MP_BUS_REQUEST_N_OE[PROCESSOR_ID_INPUTS - 3'h1];
  endproperty
  a_grant: assert property (p_grant) else $error("grant late");
  a_hiz: assert property (p_hiz) else $error("bus driven");
  a_prio: assert property (p_prio) else $error("peer beats host");
  a_hold: assert property (p_hold) else $error("grant dropped");
  a_goe: assert property (p_goe) else $error("slave drives grant");
  a_od: assert property (p_od) else $error("ack drives high");
  a_ackoff: assert property (p_ackoff) else $error("ack driven");
  a_own: assert property (p_own) else $error("wrong line");
endmodule

// ### host_model.sv
// Host model: request, select and pulled-up shared wires
`timescale 1ns/1ps
module host_model (
  // Host intent
  input  wire want,
  input  wire pick,
  // Device drive of the shared wires
  input  wire g_out,
  input  wire g_oe,
  input  wire a_out,
  input  wire a_oe,
  // Host pins and pulled-up wires
  output wire hbr_n,
  output wire cs_n,
  output wire grant_n,
  output wire ready
);
  assign hbr_n   = ~want;
  assign cs_n    = ~(want & pick);
  assign grant_n = g_oe ? g_out : 1'b1;
  assign ready   = a_oe ? a_out : 1'b1;
endmodule

// ### host_bus_handover_test.sv
// Self-checking bench for the host bus handover block
`timescale 1ns/1ps
`define CHK(n, e, a) begin checks_done++; if ((a) !== (e)) begin err_total++; \
  $display("mismatch %s exp %h got %h", n, e, a); end end
module host_bus_handover_test;
  reg        CLK = 1'b0, ARST_N = 1'b0, want = 1'b0, busy = 1'b0, sel = 1'b0;
  reg        need = 1'b0, mst = 1'b0;
  reg        pick = 1'b1, idle = 1'b1;
  reg  [2:0] id = 3'h2;
  reg  [5:0] peer_n = 6'h3F;
  reg  [1:0] dma_n = 2'h3;
  wire       hbr_n, cs_n, gnt_n, rdy, g_out, g_oe, a_out, a_oe, b_oe, owns, peer, obs;
  wire [5:0] m_out, m_oe;
  wire [1:0] dma;
  int        err_total = 0, checks_done = 0;
  always #12.5 CLK = ~CLK;
  host_model u_host (.want(want), .pick(pick), .g_out(g_out), .g_oe(g_oe), .a_out(a_out),
    .a_oe(a_oe), .hbr_n(hbr_n), .cs_n(cs_n), .grant_n(gnt_n), .ready(rdy));
  host_bus_handover u_dut (.CLK(CLK), .ARST_N(ARST_N), .HOST_BUS_REQUEST_N(hbr_n),
    .HOST_BUS_GRANT_N_IN(gnt_n), .HOST_BUS_GRANT_N_OUT(g_out), .HOST_BUS_GRANT_N_OE(g_oe),
    .CHIP_SELECT_N(cs_n), .ACCESS_BUSY(busy), .HOST_ACCESS_ACK_OUT(a_out),
    .HOST_ACCESS_ACK_OE(a_oe), .ACK_ACTIVE_DRIVE_SEL(sel), .PROCESSOR_ID_INPUTS(id),
    .MP_BUS_REQUEST_N_IN(m_oe & m_out | ~m_oe & peer_n), .MP_BUS_REQUEST_N_OUT(m_out),
    .MP_BUS_REQUEST_N_OE(m_oe), .CORE_BUS_NEED(need), .IS_BUS_MASTER(mst),
    .BUS_CYCLE_IDLE(idle), .EXT_BUS_OE(b_oe), .HOST_OWNS_BUS(owns),
    .PEER_REQUEST_SEEN(peer), .OBSERVED_HOST_GRANT(obs), .EXT_DMA_REQUEST_N(dma_n),
    .DMA_CH_REQUEST(dma));
  task wt(input int n); repeat (n) @(negedge CLK); endtask
  task conclude;
    if (err_total == 0 && checks_done > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task t_refuse;
    want = 1'b1; wt(8);
    `CHK("grant_oe", 1'b0, g_oe)
    `CHK("owns", 1'b0, owns)
    want = 1'b0; wt(6);
  endtask
  task t_peer;
    need = 1'b1; wt(6);
    `CHK("own_oe", 6'h02, m_oe)
    `CHK("own_req", 1'b0, m_out[1])
    peer_n = 6'h3B; wt(6);
    `CHK("peer", 1'b1, peer)
    want = 1'b1; wt(6);
    `CHK("peer_host", 1'b0, peer)
    `CHK("own_host", 1'b1, m_out[1])
    want = 1'b0; need = 1'b0; peer_n = 6'h3F; wt(8);
  endtask
  task t_dma;
    int i;
    for (i = 0; i < 4; i++) begin
      dma_n = i[1:0]; wt(5);
      `CHK("dma", ~i[1:0], dma)
    end
  endtask
  task t_grant;
    int i;
    busy = 1'b1; mst = 1'b1; need = 1'b1; idle = 1'b0; wt(6);
    `CHK("bus_on", 1'b1, b_oe)
    want = 1'b1; wt(8);
    `CHK("grant_wait", 1'b1, gnt_n)
    `CHK("bus_oe", 1'b0, b_oe)
    idle = 1'b1;
    for (i = 0; i < 12 && gnt_n !== 1'b0; i++) wt(1);
    `CHK("grant", 1'b0, gnt_n)
    `CHK("owns_on", 1'b1, owns)
    `CHK("grant_oe_on", 1'b1, g_oe)
    wt(4);
    `CHK("observed", 1'b1, obs)
    `CHK("ack_wait", 1'b0, rdy)
    pick = 1'b0; wt(4);
    `CHK("ack_cs", 1'b0, a_oe)
    pick = 1'b1; wt(4);
    busy = 1'b0; wt(3);
    `CHK("ack_ready", 1'b1, rdy)
    `CHK("ack_oe", sel, a_oe)
    `CHK("held", 1'b0, gnt_n)
    want = 1'b0; wt(6);
    `CHK("released", 1'b1, gnt_n)
    `CHK("ack_off", 1'b0, a_oe)
  endtask
  task t_reid;
    need = 1'b1; ARST_N = 1'b0; id = 3'h5; wt(2);
    `CHK("rst_bus_oe", 1'b0, b_oe)
    `CHK("rst_req_oe", 6'h00, m_oe)
    ARST_N = 1'b1; wt(1);
    `CHK("early_req_oe", 6'h00, m_oe)
    wt(5);
    `CHK("reid_oe", 6'h10, m_oe)
    `CHK("reid_req", 1'b0, m_out[4])
  endtask
  initial begin
    wt(12); ARST_N = 1'b1; wt(2);
    t_refuse; t_peer; t_dma;
    t_grant; sel = 1'b1; wt(2); t_grant;
    t_reid;
    conclude;
  end
  initial begin
    #50000; err_total++; conclude;
  end
endmodule
bind host_bus_handover hbh_checker #(.NPROC(NPROC), .IDW(IDW)) u_chk (.*);
